// File: dv/fidrb_checker.sv
// Checker: port-level properties of the feature id register bank
`timescale 1ns/1ps
`default_nettype none
module fidrb_checker
  import fidrb_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET_N,
  // Coprocessor request
  input wire logic        CP_REQ,
  input wire logic        CP_READ,
  input wire logic [3:0]  CP_COPROC,
  input wire logic [2:0]  CP_OPC1,
  input wire logic [3:0]  CP_CRN,
  input wire logic [3:0]  CP_CRM,
  input wire logic [2:0]  CP_OPC2,
  input wire logic [1:0]  CP_PRIV,
  input wire logic        CP_NONSECURE,
  input wire logic [31:0] CP_WDATA,
  // Coprocessor answer
  input wire logic        CP_ACK,
  input wire logic        CP_UNDEF,
  input wire logic [31:0] CP_RDATA
);
  // Claimed request, and the privileged read, the only access that may carry data
  logic hit;
  logic prd;
  assign hit = CP_REQ && CP_COPROC == FIDRB_COPROC_NUM && CP_OPC1 == FIDRB_OPC1 && CP_CRN == FIDRB_CRN
               && CP_CRM == FIDRB_CRM && CP_OPC2 != 3'h0 && CP_OPC2 != 3'h7;
  assign prd = hit && CP_READ && CP_PRIV != FIDRB_PRIV_USER;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // ----------------------------------------------------------------
  // Handshake and refusals
  // ----------------------------------------------------------------
  a_ack_next_cycle: assert property (hit |=> CP_ACK) else $error("claimed request not answered");
  a_no_stray_ack: assert property (!hit |=> !CP_ACK) else $error("answer without claim");
  a_idle_data_zero: assert property (!CP_ACK |-> CP_RDATA == 32'h0) else $error("data outside answer");
  a_user_refused: assert property (hit && CP_PRIV == FIDRB_PRIV_USER |=> CP_UNDEF && CP_RDATA == 32'h0)
    else $error("user access not refused");
  a_write_refused: assert property (hit && !CP_READ && CP_PRIV != FIDRB_PRIV_USER && CP_OPC2 != FIDRB_OPC2_AUX
    |=> CP_UNDEF) else $error("write to read-only word accepted");
  a_aux_reads_zero: assert property (hit && CP_PRIV != FIDRB_PRIV_USER && CP_OPC2 == FIDRB_OPC2_AUX
    |=> !CP_UNDEF && CP_RDATA == 32'h0) else $error("aux location not zero");

  // ----------------------------------------------------------------
  // Word values
  // ----------------------------------------------------------------
  a_prog_word_value: assert property (prd && CP_OPC2 == 3'h1 |=> !CP_UNDEF && CP_RDATA == 32'h0001_1011)
    else $error("programmers word wrong");
  a_debug_word_value: assert property (prd && CP_OPC2 == 3'h2 |=> !CP_UNDEF && CP_RDATA == 32'h0201_0555)
    else $error("debug word wrong");
  a_mem0_word_value: assert property (prd && CP_OPC2 == 3'h4 |=> !CP_UNDEF && CP_RDATA == 32'h1020_1105)
    else $error("memory word zero wrong");
  a_mem1_word_value: assert property (prd && CP_OPC2 == 3'h5 |=> !CP_UNDEF && CP_RDATA == 32'h2000_0000)
    else $error("memory word one wrong");
  a_mem2_word_value: assert property (prd && CP_OPC2 == 3'h6 |=> !CP_UNDEF && CP_RDATA == 32'h0124_0000)
    else $error("memory word two wrong");
endmodule : fidrb_checker
`default_nettype wire

// File: dv/tb.sv
// Testbench: self-checking bench for the feature id register bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import fidrb_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and scoreboard
  // ----------------------------------------------------------------
  logic        CLK;
  logic        RESET_N;
  logic        CP_REQ;
  logic        CP_READ;
  logic [3:0]  CP_COPROC;
  logic [2:0]  CP_OPC1;
  logic [3:0]  CP_CRN;
  logic [3:0]  CP_CRM;
  logic [2:0]  CP_OPC2;
  logic [1:0]  CP_PRIV;
  logic        CP_NONSECURE;
  logic [31:0] CP_WDATA;
  logic        CP_ACK;
  logic        CP_UNDEF;
  logic [31:0] CP_RDATA;
  logic [32:0] exp_q[$];
  int          mismatches;
  int          total_checks;

  fidrb_top DUT (.CLK(CLK), .RESET_N(RESET_N), .CP_REQ(CP_REQ), .CP_READ(CP_READ), .CP_COPROC(CP_COPROC),
    .CP_OPC1(CP_OPC1), .CP_CRN(CP_CRN), .CP_CRM(CP_CRM), .CP_OPC2(CP_OPC2), .CP_PRIV(CP_PRIV),
    .CP_NONSECURE(CP_NONSECURE), .CP_WDATA(CP_WDATA), .CP_ACK(CP_ACK), .CP_UNDEF(CP_UNDEF), .CP_RDATA(CP_RDATA));

  // 100 MHz clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Expected word per opcode2, written out as literal constants
  function automatic logic [31:0] word(input logic [2:0] o);
    case (o)
      3'h1:    return 32'h0001_1011;
      3'h2:    return 32'h0201_0555;
      3'h4:    return 32'h1020_1105;
      3'h5:    return 32'h2000_0000;
      3'h6:    return 32'h0124_0000;
      default: return 32'h0;
    endcase
  endfunction : word

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One request per cycle; REQ stays up so calls run back to back
  task automatic acc(input logic rd, input logic [1:0] pv, input logic [2:0] o2, input int bad);
    logic undef;
    @(negedge CLK);
    CP_REQ       = 1'b1;
    CP_READ      = rd;
    CP_PRIV      = pv;
    CP_OPC2      = o2;
    CP_COPROC    = (bad == 1) ? 4'hE : FIDRB_COPROC_NUM;
    CP_OPC1      = (bad == 2) ? 3'h1 : FIDRB_OPC1;
    CP_CRN       = (bad == 3) ? 4'h1 : FIDRB_CRN;
    CP_CRM       = (bad == 4) ? 4'h2 : FIDRB_CRM;
    CP_NONSECURE = 1'($urandom);
    CP_WDATA     = $urandom;
    undef        = (pv == FIDRB_PRIV_USER) || (!rd && o2 != FIDRB_OPC2_AUX);
    if (bad == 0 && o2 != 3'h0 && o2 != 3'h7)
      exp_q.push_back({undef, (undef || !rd) ? 32'h0 : word(o2)});
  endtask : acc

  task automatic idle(input string name);
    @(negedge CLK);
    CP_REQ = 1'b0;
    repeat (3) @(negedge CLK);
    $display("test %s done", name);
  endtask : idle

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // Answer watcher: a stray answer with nothing pending is a fault
  always @(negedge CLK) begin
    if (!RESET_N)
      exp_q.delete();
    else if (CP_ACK === 1'b1) begin
      if (exp_q.size() == 0)
        check(33'h1, 33'h0);
      else
        check({CP_UNDEF, CP_RDATA}, exp_q.pop_front());
    end
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #50000;
    mismatches++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {CP_REQ, CP_READ, CP_COPROC, CP_OPC1, CP_CRN, CP_CRM, CP_OPC2, CP_PRIV, CP_NONSECURE, CP_WDATA} = '0;
    RESET_N      = 1'b0;
    mismatches   = 0;
    total_checks = 0;
    void'($urandom(32'hC424));
    repeat (16) @(negedge CLK);
    RESET_N = 1'b1;
    for (int i = 0; i < 16; i++) acc(1'b1, 2'(1 + i % 3), 3'(i), 0);
    idle("read_all");
    for (int i = 0; i < 16; i++) acc(i[3], FIDRB_PRIV_USER, 3'(i), 0);
    idle("user_refused");
    for (int i = 1; i < 7; i++) acc(1'b0, 2'h3, 3'(i), 0);
    for (int i = 1; i < 7; i++) acc(1'b1, 2'h2, 3'(i), 0);
    idle("writes_ignored");
    for (int b = 1; b < 5; b++)
      for (int i = 1; i < 7; i++) acc(1'b1, 2'h1, 3'(i), b);
    idle("unclaimed");
    repeat (300) acc(1'($urandom), 2'($urandom), 3'($urandom), ($urandom_range(0, 3) == 0) ? $urandom_range(1, 4) : 0);
    idle("random_mix");
    acc(1'b1, 2'h1, 3'h2, 0);
    @(negedge CLK);
    CP_REQ  = 1'b0;
    RESET_N = 1'b0;
    #1;
    check({CP_ACK, CP_RDATA}, 33'h0);
    repeat (3) @(negedge CLK);
    RESET_N = 1'b1;
    for (int i = 1; i < 7; i++) acc(1'b1, 2'h3, 3'(i), 0);
    idle("reset_mid_run");
    check(33'(exp_q.size()), 33'h0);
    complete_run();
  end
endmodule : tb

bind fidrb_top fidrb_checker u_chk (.CLK(CLK), .RESET_N(RESET_N), .CP_REQ(CP_REQ), .CP_READ(CP_READ),
  .CP_COPROC(CP_COPROC), .CP_OPC1(CP_OPC1), .CP_CRN(CP_CRN), .CP_CRM(CP_CRM), .CP_OPC2(CP_OPC2), .CP_PRIV(CP_PRIV),
  .CP_NONSECURE(CP_NONSECURE), .CP_WDATA(CP_WDATA), .CP_ACK(CP_ACK), .CP_UNDEF(CP_UNDEF), .CP_RDATA(CP_RDATA));
`default_nettype wire

// File: rtl/fidrb_decode.sv
// Module: coprocessor request decoder for the feature id bank
`timescale 1ns/1ps
`default_nettype none
module fidrb_decode
  import fidrb_pkg::*;
(
  // Request fields
  input  wire logic [3:0] coproc,
  input  wire logic [2:0] opc1,
  input  wire logic [3:0] crn,
  input  wire logic [3:0] crm,
  input  wire logic [2:0] opc2,
  // Decode result
  output fidrb_sel_t      sel
);

  // ----------------------------------------------------------------
  // Address match
  // ----------------------------------------------------------------
  logic base_hit;

  // All bank registers share coprocessor, opcode1 and both primary fields
  assign base_hit = (coproc == FIDRB_COPROC_NUM) && (opc1 == FIDRB_OPC1) &&
                    (crn == FIDRB_CRN) && (crm == FIDRB_CRM);

  // Secondary opcode picks the word; opcode2 0 and 7 are not ours
  always_comb begin
    sel = FIDRB_SEL_NONE;
    if (base_hit) begin
      unique case (opc2)
        FIDRB_OPC2_PFR1: sel = FIDRB_SEL_PFR1;
        FIDRB_OPC2_DFR:  sel = FIDRB_SEL_DFR;
        FIDRB_OPC2_AUX:  sel = FIDRB_SEL_AUX;
        FIDRB_OPC2_MMF0: sel = FIDRB_SEL_MMF0;
        FIDRB_OPC2_MMF1: sel = FIDRB_SEL_MMF1;
        FIDRB_OPC2_MMF2: sel = FIDRB_SEL_MMF2;
        default:         sel = FIDRB_SEL_NONE;
      endcase
    end
  end

endmodule : fidrb_decode
`default_nettype wire

// File: rtl/fidrb_pkg.sv
// Package: encodings, field values and coprocessor addresses of the feature id bank
package fidrb_pkg;

  // ----------------------------------------------------------------
  // Coprocessor address of the bank
  // ----------------------------------------------------------------
  localparam logic [3:0] FIDRB_COPROC_NUM   = 4'hF;
  localparam logic [2:0] FIDRB_OPC1         = 3'h0;
  localparam logic [3:0] FIDRB_CRN          = 4'h0;
  localparam logic [3:0] FIDRB_CRM          = 4'h1;
  localparam logic [2:0] FIDRB_OPC2_PFR1    = 3'h1;
  localparam logic [2:0] FIDRB_OPC2_DFR     = 3'h2;
  localparam logic [2:0] FIDRB_OPC2_AUX     = 3'h3;
  localparam logic [2:0] FIDRB_OPC2_MMF0    = 3'h4;
  localparam logic [2:0] FIDRB_OPC2_MMF1    = 3'h5;
  localparam logic [2:0] FIDRB_OPC2_MMF2    = 3'h6;

  // ----------------------------------------------------------------
  // Privilege modes seen on the request
  // ----------------------------------------------------------------
  localparam logic [1:0] FIDRB_PRIV_USER    = 2'h0;

  // ----------------------------------------------------------------
  // Programmers feature word one fields, lsb of each nibble
  // ----------------------------------------------------------------
  localparam int         FIDRB_PFR1_TIMER_LSB = 16;
  localparam int         FIDRB_PFR1_VIRT_LSB  = 12;
  localparam int         FIDRB_PFR1_MPM_LSB   = 8;
  localparam int         FIDRB_PFR1_SEC_LSB   = 4;
  localparam int         FIDRB_PFR1_PM_LSB    = 0;
  localparam logic [3:0] FIDRB_PFR1_TIMER     = 4'h1;
  localparam logic [3:0] FIDRB_PFR1_VIRT      = 4'h1;
  localparam logic [3:0] FIDRB_PFR1_MPM       = 4'h0;
  localparam logic [3:0] FIDRB_PFR1_SEC       = 4'h1;
  localparam logic [3:0] FIDRB_PFR1_PM        = 4'h1;

  // ----------------------------------------------------------------
  // Debug feature word fields
  // ----------------------------------------------------------------
  localparam int         FIDRB_DFR_PMON_LSB   = 24;
  localparam int         FIDRB_DFR_MDBG_LSB   = 20;
  localparam int         FIDRB_DFR_MTRC_LSB   = 16;
  localparam int         FIDRB_DFR_CTRC_LSB   = 12;
  localparam int         FIDRB_DFR_MMDBG_LSB  = 8;
  localparam int         FIDRB_DFR_CSDBG_LSB  = 4;
  localparam int         FIDRB_DFR_CDBG_LSB   = 0;
  localparam logic [3:0] FIDRB_DFR_PMON       = 4'h2;
  localparam logic [3:0] FIDRB_DFR_MDBG       = 4'h0;
  localparam logic [3:0] FIDRB_DFR_MTRC       = 4'h1;
  localparam logic [3:0] FIDRB_DFR_CTRC       = 4'h0;
  localparam logic [3:0] FIDRB_DFR_DBG71      = 4'h5;

  // ----------------------------------------------------------------
  // Memory model word zero fields
  // ----------------------------------------------------------------
  localparam int         FIDRB_MMF0_INNER_LSB = 28;
  localparam int         FIDRB_MMF0_FCS_LSB   = 24;
  localparam int         FIDRB_MMF0_AUX_LSB   = 20;
  localparam int         FIDRB_MMF0_CPLM_LSB  = 16;
  localparam int         FIDRB_MMF0_SHLV_LSB  = 12;
  localparam int         FIDRB_MMF0_OUTER_LSB = 8;
  localparam int         FIDRB_MMF0_PUA_LSB   = 4;
  localparam int         FIDRB_MMF0_VMA_LSB   = 0;
  localparam logic [3:0] FIDRB_MMF0_INNER     = 4'h1;
  localparam logic [3:0] FIDRB_MMF0_FCS       = 4'h0;
  localparam logic [3:0] FIDRB_MMF0_AUX       = 4'h2;
  localparam logic [3:0] FIDRB_MMF0_CPLM      = 4'h0;
  localparam logic [3:0] FIDRB_MMF0_SHLV      = 4'h1;
  localparam logic [3:0] FIDRB_MMF0_OUTER     = 4'h1;
  localparam logic [3:0] FIDRB_MMF0_PUA       = 4'h0;
  localparam logic [3:0] FIDRB_MMF0_VMA       = 4'h5;

  // ----------------------------------------------------------------
  // Memory model word one fields
  // ----------------------------------------------------------------
  localparam int         FIDRB_MMF1_BP_LSB    = 28;
  localparam logic [3:0] FIDRB_MMF1_BP        = 4'h2;
  localparam logic [3:0] FIDRB_MMF1_L1OPS     = 4'h0;

  // ----------------------------------------------------------------
  // Memory model word two fields
  // ----------------------------------------------------------------
  localparam int         FIDRB_MMF2_HWAF_LSB  = 28;
  localparam int         FIDRB_MMF2_WFI_LSB   = 24;
  localparam int         FIDRB_MMF2_BAR_LSB   = 20;
  localparam int         FIDRB_MMF2_UTLB_LSB  = 16;
  localparam logic [3:0] FIDRB_MMF2_HWAF      = 4'h0;
  localparam logic [3:0] FIDRB_MMF2_WFI       = 4'h1;
  localparam logic [3:0] FIDRB_MMF2_BAR       = 4'h2;
  localparam logic [3:0] FIDRB_MMF2_UTLB      = 4'h4;
  localparam logic [3:0] FIDRB_MMF2_OTHER     = 4'h0;

  // Read data reset value
  localparam logic [31:0] FIDRB_RDATA_RST     = 32'h0000_0000;

  // Register selection
  typedef enum logic [2:0] {
    FIDRB_SEL_NONE = 3'h0,
    FIDRB_SEL_PFR1 = 3'h1,
    FIDRB_SEL_DFR  = 3'h2,
    FIDRB_SEL_AUX  = 3'h3,
    FIDRB_SEL_MMF0 = 3'h4,
    FIDRB_SEL_MMF1 = 3'h5,
    FIDRB_SEL_MMF2 = 3'h6
  } fidrb_sel_t;

endpackage : fidrb_pkg

// File: rtl/fidrb_top.sv
// Module: feature identification register bank on the coprocessor port
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Read-only, both security states, privileged only
// - Auxiliary feature location reads zero, ignores writes
// - Programmers word one: top zero, timer one
// - Virtualization one, microcontroller model zero
// - Security extensions one, standard model one
// - Opcode2 one selects programmers word one
// - Debug word: top zero, monitors two
// - No microcontroller debug, mapped trace, no cptrace
// - Three debug model fields read five
// - Opcode2 two selects debug word
// - Word zero: inner one, fcs zero, aux two
// - No coupled memory; levels, outer one; pua zero
// - Virtual memory field reads five
// - Opcode2 four selects memory word zero
// - Memory word one predictor field reads two
// - All other memory word one fields zero
// - Opcode2 five selects memory word one
// - Word two: flag zero, stall one, barriers two
// - Unified tlb field reads four
// - Lower four word two fields zero
// - Opcode2 six selects memory word two
module fidrb_top
  import fidrb_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // Coprocessor request
  input  wire logic        CP_REQ,
  input  wire logic        CP_READ,
  input  wire logic [3:0]  CP_COPROC,
  input  wire logic [2:0]  CP_OPC1,
  input  wire logic [3:0]  CP_CRN,
  input  wire logic [3:0]  CP_CRM,
  input  wire logic [2:0]  CP_OPC2,
  input  wire logic [1:0]  CP_PRIV,
  input  wire logic        CP_NONSECURE,
  input  wire logic [31:0] CP_WDATA,
  // Coprocessor answer
  output logic             CP_ACK,
  output logic             CP_UNDEF,
  output logic [31:0]      CP_RDATA
);

  // ----------------------------------------------------------------
  // Decode and constant words
  // ----------------------------------------------------------------
  fidrb_sel_t  sel;
  logic [31:0] pfr1_word;
  logic [31:0] dfr_word;
  logic [31:0] mmf0_word;
  logic [31:0] mmf1_word;
  logic [31:0] mmf2_word;

  fidrb_decode u_decode (
    .coproc (CP_COPROC),
    .opc1   (CP_OPC1),
    .crn    (CP_CRN),
    .crm    (CP_CRM),
    .opc2   (CP_OPC2),
    .sel    (sel)
  );

  fidrb_values u_values (
    .pfr1_word (pfr1_word),
    .dfr_word  (dfr_word),
    .mmf0_word (mmf0_word),
    .mmf1_word (mmf1_word),
    .mmf2_word (mmf2_word)
  );

  // ----------------------------------------------------------------
  // Access classification
  // ----------------------------------------------------------------
  logic        hit;
  logic        priv_ok;
  logic        take_read;
  logic        take_undef;
  logic [31:0] nxt_rdata;
  logic        unused_inputs;

  // Security state and write data never influence the answer
  assign unused_inputs = CP_NONSECURE ^ (^CP_WDATA);

  assign hit     = CP_REQ && (sel != FIDRB_SEL_NONE);
  assign priv_ok = (CP_PRIV != FIDRB_PRIV_USER);

  // Privileged read returns data; user access or a write to any word but the auxiliary location is undefined
  assign take_read  = hit && priv_ok && CP_READ;
  // Privileged writes to the auxiliary location are silently acked, as it is write-ignore
  assign take_undef = hit && (!priv_ok ||
                      (!CP_READ && (sel != FIDRB_SEL_AUX)));

  // Word multiplexer; the auxiliary location is a constant zero
  always_comb begin
    nxt_rdata = FIDRB_RDATA_RST;
    unique case (sel)
      FIDRB_SEL_PFR1: nxt_rdata = pfr1_word;
      FIDRB_SEL_DFR:  nxt_rdata = dfr_word;
      FIDRB_SEL_AUX:  nxt_rdata = FIDRB_RDATA_RST;
      FIDRB_SEL_MMF0: nxt_rdata = mmf0_word;
      FIDRB_SEL_MMF1: nxt_rdata = mmf1_word;
      FIDRB_SEL_MMF2: nxt_rdata = mmf2_word;
      default:        nxt_rdata = FIDRB_RDATA_RST;
    endcase
  end

  // ----------------------------------------------------------------
  // Answer registers
  // ----------------------------------------------------------------
  logic        ack_ff;
  logic        undef_ff;
  logic [31:0] rdata_ff;

  // Ack every claimed access one cycle after it is presented
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= hit;
    end
  end

  // Undefined flag travels with the ack
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      undef_ff <= 1'b0;
    end else begin
      undef_ff <= take_undef;
    end
  end

  // Data is zero unless a legal read, so user code never sees a value
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_ff <= FIDRB_RDATA_RST;
    end else if (take_read) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= FIDRB_RDATA_RST;
    end
  end

  assign CP_ACK   = ack_ff;
  assign CP_UNDEF = undef_ff;
  assign CP_RDATA = rdata_ff;

endmodule : fidrb_top
`default_nettype wire

// File: rtl/fidrb_values.sv
// Module: constant feature id word assembly
`timescale 1ns/1ps
`default_nettype none
module fidrb_values
  import fidrb_pkg::*;
(
  // Constant words
  output logic [31:0] pfr1_word,
  output logic [31:0] dfr_word,
  output logic [31:0] mmf0_word,
  output logic [31:0] mmf1_word,
  output logic [31:0] mmf2_word
);

  // ----------------------------------------------------------------
  // Word assembly; upper reserved nibbles read as zero
  // ----------------------------------------------------------------
  always_comb begin
    pfr1_word = 32'h0000_0000;
    pfr1_word[FIDRB_PFR1_TIMER_LSB +: 4] = FIDRB_PFR1_TIMER;
    pfr1_word[FIDRB_PFR1_VIRT_LSB +: 4]  = FIDRB_PFR1_VIRT;
    pfr1_word[FIDRB_PFR1_MPM_LSB +: 4]   = FIDRB_PFR1_MPM;
    pfr1_word[FIDRB_PFR1_SEC_LSB +: 4]   = FIDRB_PFR1_SEC;
    pfr1_word[FIDRB_PFR1_PM_LSB +: 4]    = FIDRB_PFR1_PM;
  end

  always_comb begin
    dfr_word = 32'h0000_0000;
    dfr_word[FIDRB_DFR_PMON_LSB +: 4]  = FIDRB_DFR_PMON;
    dfr_word[FIDRB_DFR_MDBG_LSB +: 4]  = FIDRB_DFR_MDBG;
    dfr_word[FIDRB_DFR_MTRC_LSB +: 4]  = FIDRB_DFR_MTRC;
    dfr_word[FIDRB_DFR_CTRC_LSB +: 4]  = FIDRB_DFR_CTRC;
    dfr_word[FIDRB_DFR_MMDBG_LSB +: 4] = FIDRB_DFR_DBG71;
    dfr_word[FIDRB_DFR_CSDBG_LSB +: 4] = FIDRB_DFR_DBG71;
    dfr_word[FIDRB_DFR_CDBG_LSB +: 4]  = FIDRB_DFR_DBG71;
  end

  always_comb begin
    mmf0_word = 32'h0000_0000;
    mmf0_word[FIDRB_MMF0_INNER_LSB +: 4] = FIDRB_MMF0_INNER;
    mmf0_word[FIDRB_MMF0_FCS_LSB +: 4]   = FIDRB_MMF0_FCS;
    mmf0_word[FIDRB_MMF0_AUX_LSB +: 4]   = FIDRB_MMF0_AUX;
    mmf0_word[FIDRB_MMF0_CPLM_LSB +: 4]  = FIDRB_MMF0_CPLM;
    mmf0_word[FIDRB_MMF0_SHLV_LSB +: 4]  = FIDRB_MMF0_SHLV;
    mmf0_word[FIDRB_MMF0_OUTER_LSB +: 4] = FIDRB_MMF0_OUTER;
    mmf0_word[FIDRB_MMF0_PUA_LSB +: 4]   = FIDRB_MMF0_PUA;
    mmf0_word[FIDRB_MMF0_VMA_LSB +: 4]   = FIDRB_MMF0_VMA;
  end

  // Word one: every nibble below the predictor field is "not supported"
  always_comb begin
    mmf1_word = {8{FIDRB_MMF1_L1OPS}};
    mmf1_word[FIDRB_MMF1_BP_LSB +: 4] = FIDRB_MMF1_BP;
  end

  always_comb begin
    mmf2_word = {8{FIDRB_MMF2_OTHER}};
    mmf2_word[FIDRB_MMF2_HWAF_LSB +: 4] = FIDRB_MMF2_HWAF;
    mmf2_word[FIDRB_MMF2_WFI_LSB +: 4]  = FIDRB_MMF2_WFI;
    mmf2_word[FIDRB_MMF2_BAR_LSB +: 4]  = FIDRB_MMF2_BAR;
    mmf2_word[FIDRB_MMF2_UTLB_LSB +: 4] = FIDRB_MMF2_UTLB;
  end

endmodule : fidrb_values
`default_nettype wire
